// >>> verilog/asfe_frame_engine.sv
// Async serial frame engine with AXI4-Lite register slave
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module asfe_frame_engine #(
  parameter int unsigned WORD_W = 8
) (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [asfe_pkg::AW-1:0]  s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [asfe_pkg::AW-1:0]  s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic                     rx_input_stage,
  input  wire logic                     tx_monitor_input_stage,
  input  wire logic                     stop_mode,
  output logic                          tx_out
);
  localparam int unsigned BI_W = $clog2(WORD_W);
  localparam logic [BI_W-1:0] BI_LAST = BI_W'(WORD_W - 1);

  generate
    if (WORD_W < 2 || WORD_W > asfe_pkg::RXD_W)
    begin : g_bad_word
      $error("WORD_W must lie between 2 and 16");
    end
  endgenerate

  typedef struct packed {
    asfe_pkg::asfe_ctrl_t  ctrl;
    asfe_pkg::asfe_tim_t   tim;
    logic                  en_d, stop_d, rx_d, tx_d, rx_idle, tx_idle;
    logic [6:0]            rx_icnt, tx_icnt;
    asfe_pkg::asfe_state_t rx_st, tx_st;
    logic [5:0]            rx_bits, tx_bits;
    logic [BI_W-1:0]       rx_bi, tx_bi;
    logic [WORD_W-1:0]     rx_word, rx_buf, tx_word, tx_hold;
    logic                  rx_par, rx_stp, rx_back, rx_bval, rx_bpar, rx_berr, rx_blast;
    logic                  tx_par, tx_stp, tx_wval, tx_full, tx_out;
    logic                  bvalid, rvalid;
    logic [1:0]            bresp, rresp;
    logic [31:0]           rdata;
  } asfe_st_t;

  asfe_st_t   st_r;
  asfe_st_t   st_nxt;
  logic       en;
  logic       pm_on;
  logic       odd;
  logic       wr;
  logic       rd;
  logic       rx_edge;
  logic       rx_fall;
  logic       tx_edge;
  logic       cnt_rst;
  logic       rx_go;
  logic       tx_go;
  logic [6:0] idle_tgt;
  logic       rt_smp;
  logic       rt_bend;
  logic       rt_bitv;
  logic       tt_tq;
  logic       tt_bend;

  asfe_tq_if u_cfg ();

  assign u_cfg.dctq = st_r.tim.dctq;
  assign u_cfg.sp   = st_r.tim.sp;
  assign u_cfg.pctq = st_r.tim.pctq;
  assign u_cfg.smd  = st_r.ctrl.smd;

  // Receiver and transmitter keep their own bit position
  asfe_bit_timer u_rx_tmr (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cfg     (u_cfg),
    .restart (rx_go),
    .din     (rx_input_stage),
    .tq      (),
    .smp     (rt_smp),
    .bend    (rt_bend),
    .bitv    (rt_bitv)
  );

  asfe_bit_timer u_tx_tmr (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cfg     (u_cfg),
    .restart (tx_go),
    .din     (tx_monitor_input_stage),
    .tq      (tt_tq),
    .smp     (),
    .bend    (tt_bend),
    .bitv    ()
  );

  assign en = st_r.ctrl.mode == asfe_pkg::MODE_ASYNC
           && st_r.ctrl.trm == asfe_pkg::TRM_ASYNC;
  assign pm_on    = st_r.ctrl.pm == asfe_pkg::PM_EVEN || st_r.ctrl.pm == asfe_pkg::PM_ODD;
  assign odd      = st_r.ctrl.pm == asfe_pkg::PM_ODD;
  assign idle_tgt = 7'({1'b0, st_r.tim.fle} + (pm_on ? asfe_pkg::IDLE_PAR
                                                      : asfe_pkg::IDLE_NOPAR));
  assign rx_edge  = rx_input_stage != st_r.rx_d;
  assign rx_fall  = rx_edge && !rx_input_stage;
  assign tx_edge  = tx_monitor_input_stage != st_r.tx_d;
  assign cnt_rst  = (en && !st_r.en_d) || (!stop_mode && st_r.stop_d);
  assign rx_go    = st_r.rx_st == asfe_pkg::S_IDLE && en && rx_fall
                 && (st_r.rx_idle || st_r.rx_back);
  assign tx_go    = st_r.tx_st == asfe_pkg::S_IDLE && en && st_r.tx_idle
                 && st_r.tx_full && tt_tq;
  assign wr       = s_axi_awvalid && s_axi_wvalid && !st_r.bvalid;
  assign rd       = s_axi_arvalid && !st_r.rvalid;

  assign s_axi_awready = wr;
  assign s_axi_wready  = wr;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rresp   = st_r.rresp;
  assign s_axi_rdata   = st_r.rdata;
  assign tx_out        = st_r.tx_out;

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] d, logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (d & m);
  endfunction : merge

  // Bit order inside a data word
  function automatic logic [BI_W-1:0] bit_idx(logic [BI_W-1:0] bi, logic msb);
    return msb ? BI_W'(BI_LAST - bi) : bi;
  endfunction : bit_idx

  // Hand a finished receive word to software with its status
  function automatic asfe_st_t push(asfe_st_t s, logic last, logic p, logic e);
    s.rx_buf   = s.rx_word;
    s.rx_bval  = 1'b1;
    s.rx_blast = last;
    s.rx_bpar  = p;
    s.rx_berr  = e;
    s.rx_word  = '0;
    return s;
  endfunction : push

  always_comb
  begin
    st_nxt = st_r;
    // Register writes
    if (st_r.bvalid && s_axi_bready)
      st_nxt.bvalid = 1'b0;
    if (wr)
    begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = asfe_pkg::RESP_OKAY;
      case (s_axi_awaddr)
        asfe_pkg::OFS_CTRL: st_nxt.ctrl = merge(st_r.ctrl, s_axi_wdata, s_axi_wstrb);
        asfe_pkg::OFS_TIM:  st_nxt.tim = merge(st_r.tim, s_axi_wdata, s_axi_wstrb);
        asfe_pkg::OFS_STAT:
        begin
          if (s_axi_wstrb[0] && s_axi_wdata[asfe_pkg::STAT_RXIDLE])
            st_nxt.rx_idle = 1'b0;
          if (s_axi_wstrb[0] && s_axi_wdata[asfe_pkg::STAT_TXIDLE])
            st_nxt.tx_idle = 1'b0;
        end
        asfe_pkg::OFS_TXD:
        begin
          if (!st_r.tx_full && s_axi_wstrb[0])
          begin
            st_nxt.tx_hold = s_axi_wdata[WORD_W-1:0];
            st_nxt.tx_full = 1'b1;
          end
        end
        asfe_pkg::OFS_RXD: ;
        default: st_nxt.bresp = asfe_pkg::RESP_SLVERR;
      endcase
    end
    // Register reads; reading receive data frees the buffer
    if (st_r.rvalid && s_axi_rready)
      st_nxt.rvalid = 1'b0;
    if (rd)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = asfe_pkg::RESP_OKAY;
      st_nxt.rdata  = '0;
      case (s_axi_araddr)
        asfe_pkg::OFS_CTRL: st_nxt.rdata = st_r.ctrl;
        asfe_pkg::OFS_TIM:  st_nxt.rdata = st_r.tim;
        asfe_pkg::OFS_STAT:
        begin
          st_nxt.rdata[asfe_pkg::STAT_RXIDLE] = st_r.rx_idle;
          st_nxt.rdata[asfe_pkg::STAT_TXIDLE] = st_r.tx_idle;
          st_nxt.rdata[asfe_pkg::STAT_RXVAL]  = st_r.rx_bval;
          st_nxt.rdata[asfe_pkg::STAT_TXFULL] = st_r.tx_full;
          st_nxt.rdata[asfe_pkg::STAT_PAR]    = st_r.rx_bpar;
          st_nxt.rdata[asfe_pkg::STAT_PARITY_ERROR_FLAG]   = st_r.rx_berr;
        end
        asfe_pkg::OFS_RXD:
        begin
          st_nxt.rdata[WORD_W-1:0]          = st_r.rx_buf;
          st_nxt.rdata[asfe_pkg::RXD_PAR]   = st_r.rx_bpar;
          st_nxt.rdata[asfe_pkg::RXD_PARITY_ERROR_FLAG]  = st_r.rx_berr;
          st_nxt.rdata[asfe_pkg::RXD_LAST]  = st_r.rx_blast;
          st_nxt.rx_bval = 1'b0;
        end
        asfe_pkg::OFS_TXD: ;
        default: st_nxt.rresp = asfe_pkg::RESP_SLVERR;
      endcase
    end
    st_nxt.en_d   = en;
    st_nxt.stop_d = stop_mode;
    st_nxt.rx_d   = rx_input_stage;
    st_nxt.tx_d   = tx_monitor_input_stage;
    // Receiver
    if (rx_go)
    begin
      st_nxt.rx_st   = asfe_pkg::S_START;
      st_nxt.rx_back = 1'b0;
    end
    else if (st_r.rx_st == asfe_pkg::S_IDLE && rt_bend)
      st_nxt.rx_back = 1'b0;
    if (rt_smp)
    begin
      unique case (st_r.rx_st)
        asfe_pkg::S_IDLE: ;
        asfe_pkg::S_START:
        begin
          if (rt_bitv)
            st_nxt.rx_st = asfe_pkg::S_IDLE;
          else
          begin
            st_nxt.rx_st   = asfe_pkg::S_DATA;
            st_nxt.rx_bits = '0;
            st_nxt.rx_bi   = '0;
            st_nxt.rx_par  = 1'b0;
            st_nxt.rx_word = '0;
          end
        end
        asfe_pkg::S_DATA:
        begin
          st_nxt.rx_word[bit_idx(st_r.rx_bi, st_r.ctrl.sdir)] = rt_bitv;
          st_nxt.rx_par  = st_r.rx_par ^ rt_bitv;
          st_nxt.rx_bits = 6'(st_r.rx_bits + 1'b1);
          st_nxt.rx_bi   = BI_W'(st_r.rx_bi + 1'b1);
          if (st_r.rx_bits == st_r.tim.fle)
          begin
            st_nxt.rx_stp = 1'b0;
            st_nxt.rx_st  = pm_on ? asfe_pkg::S_PAR : asfe_pkg::S_STOP;
            if (!pm_on)
              st_nxt = push(st_nxt, 1'b1, 1'b0, 1'b0);
          end
          else if (st_r.rx_bi == BI_LAST)
          begin
            st_nxt    = push(st_nxt, 1'b0, 1'b0, 1'b0);
            st_nxt.rx_bi = '0;
          end
        end
        asfe_pkg::S_PAR:
        begin
          st_nxt = push(st_nxt, 1'b1, rt_bitv, rt_bitv ^ st_r.rx_par ^ odd);
          st_nxt.rx_st = asfe_pkg::S_STOP;
        end
        asfe_pkg::S_STOP:
        begin
          if (st_r.rx_stp == st_r.ctrl.stpb)
          begin
            st_nxt.rx_st   = asfe_pkg::S_IDLE;
            st_nxt.rx_back = 1'b1;
          end
          else
            st_nxt.rx_stp = 1'b1;
        end
        default: st_nxt.rx_st = asfe_pkg::S_IDLE;
      endcase
    end
    // Transmitter
    if (tx_go)
    begin
      st_nxt.tx_st  = asfe_pkg::S_START;
      st_nxt.tx_out = 1'b0;
    end
    else if (tt_bend)
    begin
      unique case (st_r.tx_st)
        asfe_pkg::S_IDLE: ;
        asfe_pkg::S_START, asfe_pkg::S_DATA:
        begin
          if (st_r.tx_st == asfe_pkg::S_DATA && st_r.tx_bits == st_r.tim.fle)
          begin
            st_nxt.tx_stp = 1'b0;
            st_nxt.tx_st  = pm_on ? asfe_pkg::S_PAR : asfe_pkg::S_STOP;
            st_nxt.tx_out = pm_on ? st_r.tx_par ^ odd : 1'b1;
          end
          else
          begin
            if (st_r.tx_st == asfe_pkg::S_START)
            begin
              st_nxt.tx_st   = asfe_pkg::S_DATA;
              st_nxt.tx_bits = '0;
              st_nxt.tx_par  = 1'b0;
            end
            else
              st_nxt.tx_bits = 6'(st_r.tx_bits + 1'b1);
            if (st_r.tx_st == asfe_pkg::S_START || st_r.tx_bi == BI_LAST)
            begin
              st_nxt.tx_bi   = '0;
              st_nxt.tx_word = st_nxt.tx_full ? st_nxt.tx_hold : '0;
              st_nxt.tx_wval = st_nxt.tx_full;
              st_nxt.tx_full = 1'b0;
            end
            else
              st_nxt.tx_bi = BI_W'(st_r.tx_bi + 1'b1);
            st_nxt.tx_out = st_nxt.tx_wval
                          ? st_nxt.tx_word[bit_idx(st_nxt.tx_bi, st_r.ctrl.sdir)]
                          : st_r.ctrl.pdl;
            st_nxt.tx_par = st_nxt.tx_par ^ st_nxt.tx_out;
          end
        end
        asfe_pkg::S_PAR:
        begin
          st_nxt.tx_st  = asfe_pkg::S_STOP;
          st_nxt.tx_out = 1'b1;
        end
        asfe_pkg::S_STOP:
        begin
          if (st_r.tx_stp == st_r.ctrl.stpb)
            st_nxt.tx_st = asfe_pkg::S_IDLE;
          else
            st_nxt.tx_stp = 1'b1;
        end
        default:
        begin
          st_nxt.tx_st  = asfe_pkg::S_IDLE;
          st_nxt.tx_out = 1'b1;
        end
      endcase
    end
    // Idle detection per line; set after any clear above, counter untouched by it
    // First counted bit end is partial, so one extra keeps the wait full length
    if (cnt_rst || rx_edge)
      st_nxt.rx_icnt = '0;
    else if (rt_bend && rx_input_stage && st_r.rx_icnt <= idle_tgt)
      st_nxt.rx_icnt = 7'(st_r.rx_icnt + 1'b1);
    if (en && rx_input_stage && !rx_edge && !cnt_rst
        && (!st_r.ctrl.idm || st_r.rx_icnt > idle_tgt))
      st_nxt.rx_idle = 1'b1;
    if (cnt_rst || tx_edge)
      st_nxt.tx_icnt = '0;
    else if (tt_bend && tx_monitor_input_stage && st_r.tx_icnt <= idle_tgt)
      st_nxt.tx_icnt = 7'(st_r.tx_icnt + 1'b1);
    if (en && tx_monitor_input_stage && !tx_edge && !cnt_rst
        && (!st_r.ctrl.idm || st_r.tx_icnt > idle_tgt))
      st_nxt.tx_idle = 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r        <= '0;
      st_r.ctrl   <= asfe_pkg::CTRL_RST;
      st_r.tim    <= asfe_pkg::TIM_RST;
      st_r.rx_st  <= asfe_pkg::S_IDLE;
      st_r.tx_st  <= asfe_pkg::S_IDLE;
      st_r.rx_d   <= 1'b1;
      st_r.tx_d   <= 1'b1;
      st_r.tx_out <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_tx_start_low: assert property (st_r.tx_st == asfe_pkg::S_START |-> !tx_out)
    else $error("start bit not low");
  a_tx_rest_high: assert property (st_r.tx_st == asfe_pkg::S_IDLE |-> tx_out)
    else $error("line not high between frames");
  a_tx_stop_high: assert property (st_r.tx_st == asfe_pkg::S_STOP |-> tx_out)
    else $error("stop bit not high");
  a_tx_gate_idle: assert property (st_r.tx_st == asfe_pkg::S_START
      && $past(st_r.tx_st) == asfe_pkg::S_IDLE |-> $past(st_r.tx_idle))
    else $error("frame sent without transmit idle flag");
  a_tx_par_bit: assert property (st_r.tx_st == asfe_pkg::S_PAR
      && $past(st_r.tx_st) == asfe_pkg::S_DATA |-> tx_out == (st_r.tx_par ^ odd))
    else $error("parity bit wrong");
  a_rx_noise_drop: assert property (st_r.rx_st == asfe_pkg::S_START && rt_smp && rt_bitv
      |=> st_r.rx_st == asfe_pkg::S_IDLE)
    else $error("noisy start bit not dropped");
  a_rx_gate_idle: assert property (st_r.rx_st == asfe_pkg::S_START
      && $past(st_r.rx_st) == asfe_pkg::S_IDLE |-> $past(st_r.rx_idle) || $past(st_r.rx_back))
    else $error("reception without idle flag");
  a_rx_par_err: assert property (st_r.rx_st == asfe_pkg::S_PAR && rt_smp
      |=> st_r.rx_bval && st_r.rx_bpar == $past(rt_bitv)
          && st_r.rx_berr == ($past(rt_bitv) ^ $past(st_r.rx_par) ^ $past(odd)))
    else $error("received parity status wrong");
  a_idle_target: assert property (!$past(st_r.rx_idle) && st_r.rx_idle && st_r.ctrl.idm
      && $past(st_r.ctrl.idm) |-> $past(st_r.rx_icnt) > $past(idle_tgt))
    else $error("receive idle set too early");
  a_clear_keeps_cnt: assert property (wr && s_axi_awaddr == asfe_pkg::OFS_STAT
      && !rx_edge && !cnt_rst && !rt_bend |=> st_r.rx_icnt == $past(st_r.rx_icnt))
    else $error("idle counter disturbed by flag clear");
endmodule : asfe_frame_engine
`default_nettype wire

// >>> verilog/asfe_pkg.sv
// Constants and types of the async serial frame engine
// Operation
// - Line rests at 1 between frames; one start bit at 0 opens each frame.
// - Data field is 1 to 64 bits, field value plus one.
// - With parity on, even or odd parity bit follows the last data bit.
// - Receiver stores received parity value and parity error with the data.
// - One or two stop bits at 1 close a frame; next start may follow.
// - Start, parity and stop bits are made and removed by the state machine.
// - Software clears idle flags; a running frame still completes normally.
// - Transmit frames start only while the transmit idle flag is set; reception also right after a final stop sample.
// - Idle mode bit 0 declares the line idle without the full count.
// - Full idle needs data bits plus 2, or plus 3 with parity, high bits.
// - Idle count restarts on line edges, stop-mode exit and mode enable.
// - Clearing an idle flag leaves the idle counter running.
// - Idle wait counts whole bit times; never shorter than programmed.
// - Falling edge while idle or after final stop sample opens reception.
// - Start bit sampled as 1 is noise; receiver returns to idle.
// - Frame spans several data words; empty buffer sends passive level.
// - Shift direction 0 sends and receives least significant bit first.
// - Quanta per bit equal the quanta field plus one.
// - Bit value is direct sample or majority of latest three quanta.
// - Shared timing setup, separate counters; transmit aligns to quanta.
package asfe_pkg;
  localparam int unsigned TQ_W  = 6;
  localparam int unsigned AW    = 8;
  localparam int unsigned RXD_W = 16;

  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_TIM  = 8'h04;
  localparam logic [AW-1:0] OFS_STAT = 8'h08;
  localparam logic [AW-1:0] OFS_TXD  = 8'h0C;
  localparam logic [AW-1:0] OFS_RXD  = 8'h10;

  localparam int unsigned STAT_RXIDLE = 0;
  localparam int unsigned STAT_TXIDLE = 1;
  localparam int unsigned STAT_RXVAL  = 2;
  localparam int unsigned STAT_TXFULL = 3;
  localparam int unsigned STAT_PAR    = 4;
  localparam int unsigned STAT_PARITY_ERROR_FLAG   = 5;
  localparam int unsigned RXD_PAR     = 16;
  localparam int unsigned RXD_PARITY_ERROR_FLAG    = 17;
  localparam int unsigned RXD_LAST    = 18;

  localparam logic [3:0] MODE_ASYNC = 4'h2;
  localparam logic [1:0] TRM_ASYNC  = 2'h1;
  localparam logic [1:0] PM_EVEN    = 2'h2;
  localparam logic [1:0] PM_ODD     = 2'h3;
  localparam logic [6:0] IDLE_NOPAR = 7'h03;
  localparam logic [6:0] IDLE_PAR   = 7'h04;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] TIM_RST  = 32'h0700_080F;

  typedef struct packed {
    logic [18:0] rsv;
    logic        pdl;
    logic        sdir;
    logic        smd;
    logic        idm;
    logic        stpb;
    logic [1:0]  pm;
    logic [1:0]  trm;
    logic [3:0]  mode;
  } asfe_ctrl_t;

  typedef struct packed {
    logic [1:0]      rsv3;
    logic [5:0]      fle;
    logic [5:0]      rsv2;
    logic [1:0]      pctq;
    logic [1:0]      rsv1;
    logic [TQ_W-1:0] sp;
    logic [1:0]      rsv0;
    logic [TQ_W-1:0] dctq;
  } asfe_tim_t;

  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_START = 5'h02,
    S_DATA  = 5'h04,
    S_PAR   = 5'h08,
    S_STOP  = 5'h10
  } asfe_state_t;
endpackage : asfe_pkg

// >>> verilog/asfe_tq_if.sv
// Shared bit timing setup passed to the bit timers
`timescale 1ns/1ps
`default_nettype none
interface asfe_tq_if;
  logic [asfe_pkg::TQ_W-1:0] dctq;
  logic [asfe_pkg::TQ_W-1:0] sp;
  logic [1:0]                pctq;
  logic                      smd;
  modport src (output dctq, output sp, output pctq, output smd);
  modport tmr (input dctq, input sp, input pctq, input smd);
endinterface : asfe_tq_if
`default_nettype wire

// >>> verilog/asfe_bit_timer.sv
// Time quantum and bit timing counter with sample point and majority vote
`timescale 1ns/1ps
`default_nettype none
module asfe_bit_timer (
  input  wire logic  aclk,
  input  wire logic  aresetn,
  asfe_tq_if.tmr     cfg,
  input  wire logic  restart,
  input  wire logic  din,
  output logic       tq,
  output logic       smp,
  output logic       bend,
  output logic       bitv
);
  typedef struct packed {
    logic [1:0]                pre;
    logic [asfe_pkg::TQ_W-1:0] cnt;
    logic [1:0]                hist;
  } asfe_tmr_t;

  localparam int unsigned TQ_W = asfe_pkg::TQ_W;

  asfe_tmr_t r_r;
  asfe_tmr_t r_nxt;
  logic      maj;

  assign tq   = r_r.pre == cfg.pctq;
  assign smp  = tq && r_r.cnt == cfg.sp;
  assign bend = tq && r_r.cnt == cfg.dctq;
  assign maj  = (r_r.hist[1] & r_r.hist[0]) | (r_r.hist[1] & din) | (r_r.hist[0] & din);
  assign bitv = cfg.smd ? maj : din;

  always_comb
  begin
    r_nxt = r_r;
    if (restart)
    begin
      r_nxt.pre = '0;
      r_nxt.cnt = '0;
    end
    else
    begin
      r_nxt.pre = tq ? 2'h0 : 2'(r_r.pre + 2'h1);
      if (tq)
      begin
        r_nxt.cnt  = bend ? '0 : TQ_W'(r_r.cnt + 1'b1);
        r_nxt.hist = {r_r.hist[0], din};
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_quanta_wrap: assert property (bend && !restart |=> r_r.cnt == '0)
    else $error("bit counter did not wrap after last quantum");
  a_sample_inside: assert property (smp |-> r_r.cnt <= cfg.dctq)
    else $error("sample point outside the bit");
endmodule : asfe_bit_timer
`default_nettype wire

// >>> verification/asfe_remote_model.sv
// Remote serial transceiver model facing the frame engine
`timescale 1ns/1ps
`default_nettype none
module asfe_remote_model #(
  parameter int BT = 16,
  parameter int NB = 11
) (
  input  wire logic aclk,
  input  wire logic tx_line,
  output logic      rx_line
);
  logic [NB-1:0] fr;
  int            nfr = 0;
  initial rx_line = 1'b1;
  // Call just after a rising edge; line rests high on return
  task automatic send(input logic [NB-4:0] d, input logic p);
    logic [NB-1:0] b;
    b = {1'b1, p, d, 1'b0};
    for (int i = 0; i < NB; i++)
    begin
      rx_line <= b[i];
      repeat (BT) @(posedge aclk);
    end
  endtask : send
  // Short low pulse on the receive line, call just after a rising edge
  task automatic glitch(input int n);
    rx_line <= 1'b0;
    repeat (n) @(posedge aclk);
    rx_line <= 1'b1;
  endtask : glitch
  // Captures start, data, parity and stop near mid bit
  initial forever
  begin
    @(negedge tx_line);
    repeat (BT / 2) @(posedge aclk);
    for (int i = 0; i < NB; i++)
    begin
      fr[i] = tx_line;
      repeat (BT) @(posedge aclk);
    end
    nfr++;
  end
endmodule : asfe_remote_model
`default_nettype wire

// >>> verification/asfe_frame_engine_tb.sv
// Self-checking bench for the async serial frame engine
`timescale 1ns/1ps
`default_nettype none
module asfe_frame_engine_tb;
  logic        aclk = 1'b0, aresetn = 1'b0, tx_out, rx_line;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        stop_mode = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, rdv;
  logic [1:0]  bresp, rresp, rsv;
  int          failures = 0, compares = 0, cyc = 0, t0, n;
  always #12.5 aclk = ~aclk;
  asfe_frame_engine #(.WORD_W(8)) i_asfe_frame_engine (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_input_stage(rx_line), .tx_monitor_input_stage(tx_out), .stop_mode(stop_mode),
    .tx_out(tx_out));
  asfe_remote_model #(.BT(16), .NB(11)) i_asfe_remote_model (
    .aclk(aclk), .tx_line(tx_out), .rx_line(rx_line));
  task automatic finish_test();
    if (failures == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      failures++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    rdv = rdata;
    rsv = rresp;
  endtask : rd
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    rd(a);
    chk(rdv, ed);
    chk({30'h0, rsv}, {30'h0, er});
  endtask : rd_chk
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(asfe_pkg::OFS_CTRL, asfe_pkg::CTRL_RST, asfe_pkg::RESP_OKAY);
    rd_chk(asfe_pkg::OFS_TIM, asfe_pkg::TIM_RST, asfe_pkg::RESP_OKAY);
    rd_chk(8'h14, 32'h0000_0000, asfe_pkg::RESP_SLVERR);
    wr(8'h14, 32'hffff_ffff, asfe_pkg::RESP_SLVERR);
    wr(asfe_pkg::OFS_CTRL, 32'h0000_0290, asfe_pkg::RESP_OKAY);
    wr(asfe_pkg::OFS_CTRL, 32'h0000_0292, asfe_pkg::RESP_OKAY);
    t0 = cyc;
    rd_chk(asfe_pkg::OFS_STAT, 32'h0000_0000, asfe_pkg::RESP_OKAY);
    do rd(asfe_pkg::OFS_STAT); while (rdv[1:0] !== 2'b11);
    chk({31'h0, (cyc - t0) >= 176 && (cyc - t0) <= 220}, 32'h1);
    // Short low glitch must not leave a received word, even after a full frame time
    @(posedge aclk);
    i_asfe_remote_model.glitch(3);
    repeat (200) @(posedge aclk);
    rd(asfe_pkg::OFS_STAT);
    chk({31'h0, rdv[2]}, 32'h0);
    // Even, odd, then even with majority sampling and most significant bit first
    for (int m = 0; m < 3; m++)
    begin
      wr(asfe_pkg::OFS_CTRL, 32'h0000_0292 | (m << 6) | (m / 2 * 32'h0000_0c00),
         asfe_pkg::RESP_OKAY);
      n = i_asfe_remote_model.nfr;
      wr(asfe_pkg::OFS_TXD, 32'h0000_00a5, asfe_pkg::RESP_OKAY);
      while (i_asfe_remote_model.nfr == n) @(posedge aclk);
      chk({21'h0, i_asfe_remote_model.fr}, {21'h0, 1'b1, ^8'ha5 ^ m[0], 8'ha5, 1'b0});
      for (int e = 0; e < 2; e++)
      begin
        @(posedge aclk);
        i_asfe_remote_model.send(8'h71, ^8'h71 ^ m[0] ^ e[0]);
        rd_chk(asfe_pkg::OFS_RXD, {13'h0, 1'b1, e[0], ^8'h71 ^ m[0] ^ e[0], 8'h00,
               (m > 1 ? 8'h8e : 8'h71)}, asfe_pkg::RESP_OKAY);
      end
    end
    // Leaving stop mode restarts idle counting, so cleared flags stay low
    stop_mode <= 1'b1;
    @(posedge aclk);
    stop_mode <= 1'b0;
    wr(asfe_pkg::OFS_STAT, 32'h0000_0003, asfe_pkg::RESP_OKAY);
    rd(asfe_pkg::OFS_STAT);
    chk({30'h0, rdv[1:0]}, 32'h0);
    wr(asfe_pkg::OFS_CTRL, 32'h0000_0092, asfe_pkg::RESP_OKAY);
    wr(asfe_pkg::OFS_STAT, 32'h0000_0003, asfe_pkg::RESP_OKAY);
    rd(asfe_pkg::OFS_STAT);
    chk({30'h0, rdv[1:0]}, 32'h3);
    finish_test();
  end
endmodule : asfe_frame_engine_tb
`default_nettype wire
